// ===== hdl/fsg_cfg.svh
// Purpose: constants for the flash state gate and direct-read control
// Assumes: 24-bit addresses, one command byte
// Notes:   clock indices count from 1 at the first clock of a frame
`ifndef FSG_CFG_SVH
`define FSG_CFG_SVH

// ****************************************
// First dummy clock index per protocol
// ****************************************
`define FSG_IDX_EXT_CMD 6'h21
`define FSG_IDX_DUAL_CMD 6'h11
`define FSG_IDX_QUAD_CMD 6'h09
`define FSG_IDX_EXT_DIR 6'h19
`define FSG_IDX_DUAL_DIR 6'h0D
`define FSG_IDX_QUAD_DIR 6'h07

// ****************************************
// Resynchronisation burst lengths
// ****************************************
`define FSG_RS_LEN0 6'h07
`define FSG_RS_LEN1 6'h09
`define FSG_RS_LEN2 6'h0D
`define FSG_RS_LEN3 6'h11
`define FSG_RS_LEN4 6'h19
`define FSG_RS_LEN5 6'h21
`define FSG_RS_LAST 3'h5

// ****************************************
// Reset values, boot field and frame counter limit
// ****************************************
`define FSG_NV_DIRECT_OFF 3'h7
`define FSG_VCFG_B3_RST 1'b1
`define FSG_CNT_MAX 6'h3F

`endif

// ===== hdl/fsg_pkg.sv
// Purpose: types shared by the flash state gate
// Assumes: nothing
// Notes:   enums carry no explicit codes
package fsg_pkg;
    typedef enum logic [1:0] {FSG_STANDBY, FSG_PROG_ERASE, FSG_SUB_SUSP, FSG_ERS_SUSP} fsg_state_e;
    typedef enum logic [3:0] {
        FSG_RD_ARRAY, FSG_RD_STATUS, FSG_PROGRAM, FSG_PROG_OTP, FSG_ERASE_SECT,
        FSG_ERASE_SUB, FSG_ERASE_BULK, FSG_WR_NV, FSG_WR_VOL, FSG_SUSPEND, FSG_RESUME
    } fsg_op_e;
    typedef enum logic [1:0] {FSG_PROTO_EXT, FSG_PROTO_DUAL, FSG_PROTO_QUAD} fsg_proto_e;
endpackage

// ===== hdl/fsg_gate.sv
// Purpose: operation gating per device state and direct-read mode control
// Assumes: frame clock i_sclk stops while i_cs_b is high
// Notes:   frame count and capture are read by i_mclk only after deselect
//
// Operation
// RL1 - The device holds exactly one of four operational states.
// RL2 - Standby accepts every operation except suspend; the code also refuses resume in standby.
// RL3 - Outside erase suspend, decisions ignore the target sector.
// RL4 - In erase suspend, program to the suspended sector is refused.
// RL5 - Array reads accepted in standby and suspends, refused while busy.
// RL6 - Read of a suspended-erase sector is accepted, data flagged unsure.
// RL7 - Status and flag status reads are accepted in every state.
// RL8 - Sector and subsector erase accepted only in standby.
// RL9 - Status, nonvolatile, OTP and bulk erase writes only in standby.
// RL10 - Volatile writes and latch commands refused only while busy.
// RL11 - Suspend accepted only while a program or erase runs.
// RL12 - Array program refused while busy and in subsector/program suspend.
// RL13 - Entry needs volatile bit 3 cleared, then confirm bit 0.
// RL14 - In direct-read mode frames carry address only, no command.
// RL15 - Confirm bit 1 exits direct-read mode and sets volatile bit 3.
// RL16 - Basic variant enters on confirm 0 without volatile bit 3.
// RL17 - Nonvolatile boot field can start the device in direct-read mode.
// RL18 - Confirm bit is taken from serial line 0 at first dummy clock.
// RL19 - Lines 1 to 3 are don't care at the first dummy clock.
// RL20 - Reset pin pulse exits direct-read; in quad only when deselected.
// RL21 - Bursts of 7,9,13,17,25,33 clocks force exit, operations untouched.
// RL22 - Host then issues reset-enable and reset-memory.
// RL23 - A refused operation changes nothing.
`timescale 1ns/10ps
`include "fsg_cfg.svh"

module fsg_gate #(
    parameter bit BASIC_DIRECT = 1'b0,
    parameter int SECTOR_W = 8
) (
    input wire logic i_mclk, // System clock
    input wire logic i_rst_b, // Power-on reset, active low
    input wire logic i_sclk, // Serial clock from host
    input wire logic i_cs_b, // Chip select, active low
    input wire logic i_serial_line_0, // Serial data line 0
    input wire logic i_rst_pin_b, // Reset pin, active low
    input wire logic i_rst_pin_en, // Reset pin enabled
    input wire fsg_pkg::fsg_proto_e i_proto, // Enabled protocol
    input wire logic [2:0] i_nv_direct_boot, // Nonvolatile boot field
    input wire logic i_frame_fast_read, // Current frame is a fast read
    input wire logic i_op_valid, // Operation request pulse
    input wire fsg_pkg::fsg_op_e i_op_class, // Operation class
    input wire logic [SECTOR_W-1:0] i_op_sector, // Target sector
    input wire logic i_op_vcfg_b3, // Volatile bit 3 value to write
    input wire logic i_pe_done, // Program or erase finished
    output logic o_op_accept, // Operation accepted pulse
    output logic o_op_refuse, // Operation refused pulse
    output logic o_read_unsure, // Read data not guaranteed
    output fsg_pkg::fsg_state_e o_state, // Operational state
    output logic o_direct_read_mode, // Direct-read mode active
    output logic o_vcfg_direct_b, // Volatile configuration bit 3
    output logic o_resync_exit // Resync sequence seen pulse
);

    // ****************************************
    // Link side on the serial clock
    // ****************************************
    logic first;
    logic [5:0] cnt;
    logic [5:0] next_cnt;
    logic cap_ok;
    logic cap_bit;
    logic [5:0] sample_idx;

    // Async set on deselect: no serial edge arrives after a frame
    always_ff @(posedge i_sclk or posedge i_cs_b) begin
        if (i_cs_b) first <= 1'b1;
        else first <= 1'b0;
    end

    assign next_cnt = first ? 6'h01 : ((cnt == `FSG_CNT_MAX) ? cnt : cnt + 6'h01);

    always_ff @(posedge i_sclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt <= 6'h00;
        end else begin
            cnt <= next_cnt;
        end
    end

    // Only line 0 is looked at; the other lines are don't care // RL19
    always_ff @(posedge i_sclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cap_ok <= 1'b0;
            cap_bit <= 1'b1;
        end else if (next_cnt == sample_idx) begin
            cap_ok <= 1'b1; // RL18
            cap_bit <= i_serial_line_0; // RL18
        end else if (first) begin
            cap_ok <= 1'b0;
        end
    end

    // ****************************************
    // Pin synchronisers on the system clock
    // ****************************************
    logic [2:0] cs_sync;
    logic [2:0] pin_sync;
    logic cs_q;
    logic cs_q_d;
    logic pin_q;
    logic pin_q_d;
    logic frame_end;
    logic pin_rst;

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cs_sync <= 3'h7;
            pin_sync <= 3'h7;
        end else begin
            cs_sync <= {cs_sync[1:0], i_cs_b};
            pin_sync <= {pin_sync[1:0], i_rst_pin_b};
        end
    end

    // A change counts once stages two and three agree
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cs_q <= 1'b1;
            cs_q_d <= 1'b1;
            pin_q <= 1'b1;
            pin_q_d <= 1'b1;
        end else begin
            if (cs_sync[1] == cs_sync[2]) begin
                cs_q <= cs_sync[2];
            end
            if (pin_sync[1] == pin_sync[2]) begin
                pin_q <= pin_sync[2];
            end
            cs_q_d <= cs_q;
            pin_q_d <= pin_q;
        end
    end

    assign frame_end = cs_q & ~cs_q_d;
    // Quad protocol honours the pin only while deselected // RL20
    assign pin_rst = ~pin_q & pin_q_d & i_rst_pin_en & ((i_proto != fsg_pkg::FSG_PROTO_QUAD) | cs_q);

    // Index is frozen while selected so the serial side sees a stable word
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sample_idx <= `FSG_IDX_EXT_CMD;
        end else if (cs_q) begin
            case (i_proto)
                fsg_pkg::FSG_PROTO_DUAL: begin
                    sample_idx <= o_direct_read_mode ? `FSG_IDX_DUAL_DIR : `FSG_IDX_DUAL_CMD; // RL14
                end
                fsg_pkg::FSG_PROTO_QUAD: begin
                    sample_idx <= o_direct_read_mode ? `FSG_IDX_QUAD_DIR : `FSG_IDX_QUAD_CMD; // RL14
                end
                default: begin
                    sample_idx <= o_direct_read_mode ? `FSG_IDX_EXT_DIR : `FSG_IDX_EXT_CMD; // RL14
                end
            endcase
        end
    end

    // ****************************************
    // Direct-read mode control
    // ****************************************
    logic boot_load;
    logic boot_sel;
    logic is_read;
    logic enter;
    logic exit_conf;
    logic rs_hit;
    logic [2:0] rs_step;
    logic [5:0] rs_len;
    logic vol_write;

    assign boot_sel = (i_nv_direct_boot != `FSG_NV_DIRECT_OFF); // RL17
    assign is_read = o_direct_read_mode | i_frame_fast_read;
    assign enter = frame_end & cap_ok & is_read & ~cap_bit
        & (o_direct_read_mode | ~o_vcfg_direct_b | BASIC_DIRECT); // RL13 RL16
    assign exit_conf = frame_end & cap_ok & o_direct_read_mode & cap_bit; // RL15

    always_comb begin
        case (rs_step)
            3'h0: rs_len = `FSG_RS_LEN0;
            3'h1: rs_len = `FSG_RS_LEN1;
            3'h2: rs_len = `FSG_RS_LEN2;
            3'h3: rs_len = `FSG_RS_LEN3;
            3'h4: rs_len = `FSG_RS_LEN4;
            default: rs_len = `FSG_RS_LEN5;
        endcase
    end

    assign rs_hit = frame_end & (cnt == rs_len) & (rs_step == `FSG_RS_LAST); // RL21

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rs_step <= 3'h0;
        end else if (frame_end) begin
            if (cnt == rs_len && rs_step != `FSG_RS_LAST) begin
                rs_step <= rs_step + 3'h1; // RL21
            end else begin
                rs_step <= (cnt == `FSG_RS_LEN0) ? 3'h1 : 3'h0;
            end
        end
    end

    // Boot field is caught on the first clock after release
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            boot_load <= 1'b1;
            o_direct_read_mode <= 1'b0;
        end else begin
            boot_load <= 1'b0;
            if (boot_load || pin_rst) begin
                o_direct_read_mode <= boot_sel; // RL17 RL20
            end else if (exit_conf || rs_hit) begin
                o_direct_read_mode <= 1'b0; // RL15 RL21
            end else if (enter) begin
                o_direct_read_mode <= 1'b1; // RL13
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_vcfg_direct_b <= `FSG_VCFG_B3_RST;
            o_resync_exit <= 1'b0;
        end else begin
            o_resync_exit <= rs_hit;
            if (pin_rst || exit_conf || rs_hit) begin
                o_vcfg_direct_b <= 1'b1; // RL15
            end else if (vol_write) begin
                o_vcfg_direct_b <= i_op_vcfg_b3;
            end
        end
    end

    // ****************************************
    // Operation gating state machine
    // ****************************************
    fsg_pkg::fsg_state_e state;
    logic allow;
    logic sect_erase;
    logic [SECTOR_W-1:0] sus_sector;
    logic [SECTOR_W-1:0] act_sector;
    logic same_sector;

    assign same_sector = (i_op_sector == sus_sector);

    // Sector only matters in erase suspend // RL3
    always_comb begin
        allow = 1'b0;
        case (i_op_class)
            fsg_pkg::FSG_RD_STATUS: allow = 1'b1; // RL7
            fsg_pkg::FSG_RD_ARRAY: allow = (state != fsg_pkg::FSG_PROG_ERASE); // RL5 RL6
            fsg_pkg::FSG_PROGRAM: begin
                allow = (state == fsg_pkg::FSG_STANDBY)
                    | ((state == fsg_pkg::FSG_ERS_SUSP) & ~same_sector); // RL4 RL12
            end
            fsg_pkg::FSG_ERASE_SECT,
            fsg_pkg::FSG_ERASE_SUB: allow = (state == fsg_pkg::FSG_STANDBY); // RL8
            fsg_pkg::FSG_PROG_OTP,
            fsg_pkg::FSG_ERASE_BULK,
            fsg_pkg::FSG_WR_NV: allow = (state == fsg_pkg::FSG_STANDBY); // RL9
            fsg_pkg::FSG_WR_VOL: allow = (state != fsg_pkg::FSG_PROG_ERASE); // RL10
            fsg_pkg::FSG_SUSPEND: allow = (state == fsg_pkg::FSG_PROG_ERASE); // RL2 RL11
            fsg_pkg::FSG_RESUME: begin
                allow = (state == fsg_pkg::FSG_SUB_SUSP) | (state == fsg_pkg::FSG_ERS_SUSP);
            end
            default: allow = 1'b0;
        endcase
    end

    assign vol_write = i_op_valid & allow & (i_op_class == fsg_pkg::FSG_WR_VOL);

    // Refused requests fall through with no state change // RL23
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state <= fsg_pkg::FSG_STANDBY;
            sect_erase <= 1'b0;
            act_sector <= '0;
            sus_sector <= '0;
        end else begin
            case (state)
                fsg_pkg::FSG_STANDBY: begin
                    if (i_op_valid && allow && i_op_class inside {fsg_pkg::FSG_PROGRAM,
                        fsg_pkg::FSG_PROG_OTP, fsg_pkg::FSG_ERASE_SECT,
                        fsg_pkg::FSG_ERASE_SUB, fsg_pkg::FSG_ERASE_BULK}) begin
                        state <= fsg_pkg::FSG_PROG_ERASE; // RL1
                        sect_erase <= (i_op_class == fsg_pkg::FSG_ERASE_SECT);
                        act_sector <= i_op_sector;
                    end
                end
                fsg_pkg::FSG_PROG_ERASE: begin
                    if (i_pe_done) begin
                        state <= fsg_pkg::FSG_STANDBY;
                    end else if (i_op_valid && i_op_class == fsg_pkg::FSG_SUSPEND) begin
                        state <= sect_erase ? fsg_pkg::FSG_ERS_SUSP : fsg_pkg::FSG_SUB_SUSP;
                        sus_sector <= act_sector;
                    end
                end
                fsg_pkg::FSG_SUB_SUSP,
                fsg_pkg::FSG_ERS_SUSP: begin
                    if (i_op_valid && i_op_class == fsg_pkg::FSG_RESUME) begin
                        state <= fsg_pkg::FSG_PROG_ERASE;
                    end
                end
                default: state <= fsg_pkg::FSG_STANDBY;
            endcase
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_op_accept <= 1'b0;
            o_op_refuse <= 1'b0;
            o_read_unsure <= 1'b0;
        end else begin
            o_op_accept <= i_op_valid & allow;
            o_op_refuse <= i_op_valid & ~allow;
            o_read_unsure <= i_op_valid & (i_op_class == fsg_pkg::FSG_RD_ARRAY)
                & (state == fsg_pkg::FSG_ERS_SUSP) & same_sector; // RL6
        end
    end

    assign o_state = state;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_b);

    a_state_legal: assert property (state == fsg_pkg::FSG_STANDBY && !i_op_valid // RL1
        |=> state == fsg_pkg::FSG_STANDBY) else $error("state moved without request");
    a_standby_suspend: assert property (i_op_valid && state == fsg_pkg::FSG_STANDBY // RL2
        && i_op_class == fsg_pkg::FSG_SUSPEND |=> o_op_refuse && !o_op_accept)
        else $error("suspend accepted in standby");
    a_status_read: assert property (i_op_valid && i_op_class == fsg_pkg::FSG_RD_STATUS // RL7
        |=> o_op_accept) else $error("status read refused");
    a_busy_read: assert property (i_op_valid && i_op_class == fsg_pkg::FSG_RD_ARRAY // RL5
        && state == fsg_pkg::FSG_PROG_ERASE |=> o_op_refuse) else $error("read while busy");
    a_erase_standby: assert property (i_op_valid && i_op_class == fsg_pkg::FSG_ERASE_SUB // RL8
        |=> o_op_accept == ($past(state) == fsg_pkg::FSG_STANDBY)) else $error("erase gate");
    a_nv_standby: assert property (i_op_valid && i_op_class == fsg_pkg::FSG_WR_NV // RL9
        && state != fsg_pkg::FSG_STANDBY |=> o_op_refuse) else $error("nv write gate");
    a_vol_gate: assert property (i_op_valid && i_op_class == fsg_pkg::FSG_WR_VOL // RL10
        && state == fsg_pkg::FSG_SUB_SUSP |=> o_op_accept) else $error("vol write gate");
    a_susp_sector: assert property (i_op_valid && i_op_class == fsg_pkg::FSG_PROGRAM // RL4
        && state == fsg_pkg::FSG_ERS_SUSP && i_op_sector == sus_sector |=> o_op_refuse)
        else $error("program to suspended sector");
    a_refuse_quiet: assert property (i_op_valid && !allow && !i_pe_done // RL23
        |=> $stable(state) && $stable(o_vcfg_direct_b)) else $error("refused op changed state");
    a_exit_vcfg: assert property ($fell(o_direct_read_mode) |-> o_vcfg_direct_b) // RL15
        else $error("exit left bit 3 clear");
    a_resync_exit: assert property (rs_hit && !pin_rst // RL21
        |=> !o_direct_read_mode && o_resync_exit) else $error("resync did not exit");
    a_resync_ops: assert property (rs_hit && state == fsg_pkg::FSG_PROG_ERASE // RL21
        && !i_pe_done && !i_op_valid |=> state == fsg_pkg::FSG_PROG_ERASE)
        else $error("resync hit ops");

    c_enter: cover property (enter && !o_direct_read_mode);
    c_resync: cover property (rs_hit && o_direct_read_mode);
    c_ers_prog: cover property (i_op_valid && allow && state == fsg_pkg::FSG_ERS_SUSP
        && i_op_class == fsg_pkg::FSG_PROGRAM);
    c_pin_rst: cover property (pin_rst);

endmodule

// ===== sim/fsg_host.sv
// Purpose: host controller model driving frames on the serial link
// Assumes: link clock period 12 ns, clock still between frames
// Notes:   line 0 toggles outside the sample clock so no stale value helps
`timescale 1ns/10ps

module fsg_host (
    output logic o_sclk, // Serial clock
    output logic o_cs_b, // Chip select, active low
    output logic o_line0, // Serial line 0
    output logic o_fast_read // Frame holds a fast read
);
    initial begin
        o_sclk = 1'b0;
        o_cs_b = 1'b1;
        o_line0 = 1'b0;
        o_fast_read = 1'b0;
    end

    // ****************************************
    // One frame of n clocks, confirm bit at clock idx
    // ****************************************
    task automatic frame(input int n, input int idx, input logic cb, input logic fr);
        int k;
        o_fast_read = fr;
        o_cs_b = 1'b0;
        for (k = 1; k <= n; k++) begin
            o_line0 = (k == idx) ? cb : ~o_line0;
            #6;
            o_sclk = 1'b1;
            #6;
            o_sclk = 1'b0;
        end
        #3;
        o_cs_b = 1'b1;
        o_line0 = ~o_line0;
        // Gap well above 6 mclk so the frame end is seen
        #100;
    endtask
endmodule

// ===== sim/tb.sv
// Purpose: self-checking bench for the state gate and direct-read control
// Assumes: default parameters, 100 MHz system clock
// Notes:   frames come from the host model, ops from local tasks
`timescale 1ns/10ps

module tb;
    logic i_mclk, i_rst_b, i_sclk, i_cs_b, i_serial_line_0, i_rst_pin_b, i_rst_pin_en;
    fsg_pkg::fsg_proto_e i_proto;
    fsg_pkg::fsg_op_e i_op_class;
    fsg_pkg::fsg_state_e o_state;
    logic [2:0] i_nv_direct_boot;
    logic [7:0] i_op_sector;
    logic i_frame_fast_read, i_op_valid, i_op_vcfg_b3, i_pe_done;
    logic o_op_accept, o_op_refuse, o_read_unsure, o_direct_read_mode, o_vcfg_direct_b;
    logic o_resync_exit;
    int error_cnt = 0;
    int tests_run = 0;
    int resync_cnt = 0;

    fsg_gate dut (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_sclk(i_sclk), .i_cs_b(i_cs_b),
        .i_serial_line_0(i_serial_line_0), .i_rst_pin_b(i_rst_pin_b),
        .i_rst_pin_en(i_rst_pin_en), .i_proto(i_proto), .i_nv_direct_boot(i_nv_direct_boot),
        .i_frame_fast_read(i_frame_fast_read), .i_op_valid(i_op_valid),
        .i_op_class(i_op_class), .i_op_sector(i_op_sector), .i_op_vcfg_b3(i_op_vcfg_b3),
        .i_pe_done(i_pe_done), .o_op_accept(o_op_accept), .o_op_refuse(o_op_refuse),
        .o_read_unsure(o_read_unsure), .o_state(o_state),
        .o_direct_read_mode(o_direct_read_mode), .o_vcfg_direct_b(o_vcfg_direct_b),
        .o_resync_exit(o_resync_exit));

    fsg_host host (.o_sclk(i_sclk), .o_cs_b(i_cs_b), .o_line0(i_serial_line_0),
        .o_fast_read(i_frame_fast_read));

    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end

    always @(posedge i_mclk) begin
        if (o_resync_exit === 1'b1) resync_cnt++;
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Exp is {unsure, accept}
    task automatic op(input fsg_pkg::fsg_op_e cls, input logic [7:0] sec, input logic [1:0] exp);
        @(posedge i_mclk);
        #1;
        i_op_valid = 1'b1;
        i_op_class = cls;
        i_op_sector = sec;
        @(posedge i_mclk);
        #1;
        i_op_valid = 1'b0;
        check({5'h00, o_read_unsure, o_op_refuse, o_op_accept}, {5'h00, exp[1], ~exp[0], exp[0]});
    endtask

    task automatic st(input fsg_pkg::fsg_state_e e);
        check({6'h00, o_state}, {6'h00, e});
    endtask

    task automatic mv(input logic m, input logic v);
        check({6'h00, o_direct_read_mode, o_vcfg_direct_b}, {6'h00, m, v});
    endtask

    task automatic pe_done;
        @(posedge i_mclk);
        #1;
        i_pe_done = 1'b1;
        @(posedge i_mclk);
        #1;
        i_pe_done = 1'b0;
    endtask

    task automatic pin_pulse;
        @(posedge i_mclk);
        #1;
        i_rst_pin_b = 1'b0;
        repeat (5) @(posedge i_mclk);
        #1;
        i_rst_pin_b = 1'b1;
        repeat (8) @(posedge i_mclk);
        #1;
    endtask

    task automatic do_reset;
        i_rst_b = 1'b0;
        repeat (3) @(posedge i_mclk);
        #1;
        i_rst_b = 1'b1;
        repeat (2) @(posedge i_mclk);
        #1;
    endtask

    task automatic test_done;
        $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        #100000;
        error_cnt++;
        test_done();
    end

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        i_rst_b = 1'b0;
        i_rst_pin_b = 1'b1;
        i_rst_pin_en = 1'b1;
        i_proto = fsg_pkg::FSG_PROTO_EXT;
        i_nv_direct_boot = 3'h7;
        i_op_valid = 1'b0;
        i_op_class = fsg_pkg::FSG_RD_STATUS;
        i_op_sector = 8'h00;
        i_op_vcfg_b3 = 1'b1;
        i_pe_done = 1'b0;
        do_reset();
        st(fsg_pkg::FSG_STANDBY);
        mv(1'b0, 1'b1);
        $display("test reset done");
        op(fsg_pkg::FSG_RD_ARRAY, 8'h01, 2'h1);
        op(fsg_pkg::FSG_RD_STATUS, 8'h01, 2'h1);
        op(fsg_pkg::FSG_WR_NV, 8'h01, 2'h1);
        op(fsg_pkg::FSG_WR_VOL, 8'h01, 2'h1);
        op(fsg_pkg::FSG_SUSPEND, 8'h01, 2'h0);
        op(fsg_pkg::FSG_RESUME, 8'h01, 2'h0);
        op(fsg_pkg::FSG_PROGRAM, 8'h02, 2'h1);
        st(fsg_pkg::FSG_PROG_ERASE);
        pe_done();
        op(fsg_pkg::FSG_PROG_OTP, 8'h02, 2'h1);
        pe_done();
        op(fsg_pkg::FSG_ERASE_BULK, 8'h02, 2'h1);
        pe_done();
        st(fsg_pkg::FSG_STANDBY);
        $display("test standby done");
        i_op_vcfg_b3 = 1'b0;
        op(fsg_pkg::FSG_ERASE_SECT, 8'h05, 2'h1);
        op(fsg_pkg::FSG_RD_ARRAY, 8'h05, 2'h0);
        op(fsg_pkg::FSG_RD_STATUS, 8'h05, 2'h1);
        op(fsg_pkg::FSG_PROGRAM, 8'h07, 2'h0);
        op(fsg_pkg::FSG_ERASE_SUB, 8'h07, 2'h0);
        op(fsg_pkg::FSG_WR_NV, 8'h07, 2'h0);
        op(fsg_pkg::FSG_PROG_OTP, 8'h07, 2'h0);
        op(fsg_pkg::FSG_WR_VOL, 8'h07, 2'h0);
        st(fsg_pkg::FSG_PROG_ERASE);
        mv(1'b0, 1'b1);
        op(fsg_pkg::FSG_SUSPEND, 8'h05, 2'h1);
        st(fsg_pkg::FSG_ERS_SUSP);
        $display("test busy done");
        i_op_vcfg_b3 = 1'b1;
        op(fsg_pkg::FSG_PROGRAM, 8'h05, 2'h0);
        op(fsg_pkg::FSG_PROGRAM, 8'h06, 2'h1);
        op(fsg_pkg::FSG_RD_ARRAY, 8'h05, 2'h3);
        op(fsg_pkg::FSG_RD_ARRAY, 8'h06, 2'h1);
        op(fsg_pkg::FSG_ERASE_SUB, 8'h06, 2'h0);
        op(fsg_pkg::FSG_ERASE_BULK, 8'h06, 2'h0);
        op(fsg_pkg::FSG_SUSPEND, 8'h06, 2'h0);
        op(fsg_pkg::FSG_WR_VOL, 8'h06, 2'h1);
        st(fsg_pkg::FSG_ERS_SUSP);
        op(fsg_pkg::FSG_RESUME, 8'h05, 2'h1);
        st(fsg_pkg::FSG_PROG_ERASE);
        pe_done();
        op(fsg_pkg::FSG_ERASE_SUB, 8'h09, 2'h1);
        op(fsg_pkg::FSG_SUSPEND, 8'h09, 2'h1);
        st(fsg_pkg::FSG_SUB_SUSP);
        op(fsg_pkg::FSG_PROGRAM, 8'h01, 2'h0);
        op(fsg_pkg::FSG_PROG_OTP, 8'h01, 2'h0);
        op(fsg_pkg::FSG_ERASE_SECT, 8'h01, 2'h0);
        op(fsg_pkg::FSG_RD_ARRAY, 8'h01, 2'h1);
        op(fsg_pkg::FSG_WR_VOL, 8'h01, 2'h1);
        op(fsg_pkg::FSG_RESUME, 8'h09, 2'h1);
        pe_done();
        st(fsg_pkg::FSG_STANDBY);
        $display("test suspend done");
        host.frame(33, 33, 1'b0, 1'b1);
        mv(1'b0, 1'b1);
        i_op_vcfg_b3 = 1'b0;
        op(fsg_pkg::FSG_WR_VOL, 8'h00, 2'h1);
        mv(1'b0, 1'b0);
        host.frame(33, 33, 1'b0, 1'b1);
        mv(1'b1, 1'b0);
        host.frame(25, 25, 1'b0, 1'b1);
        mv(1'b1, 1'b0);
        host.frame(25, 25, 1'b1, 1'b1);
        mv(1'b0, 1'b1);
        $display("test entry done");
        op(fsg_pkg::FSG_WR_VOL, 8'h00, 2'h1);
        host.frame(33, 33, 1'b0, 1'b1);
        op(fsg_pkg::FSG_ERASE_SECT, 8'h03, 2'h1);
        host.frame(7, 7, 1'b0, 1'b0);
        host.frame(9, 9, 1'b0, 1'b0);
        host.frame(13, 13, 1'b0, 1'b0);
        host.frame(17, 17, 1'b0, 1'b0);
        host.frame(25, 25, 1'b0, 1'b0);
        host.frame(33, 33, 1'b0, 1'b0);
        mv(1'b0, 1'b1);
        check(8'(resync_cnt), 8'h01);
        st(fsg_pkg::FSG_PROG_ERASE);
        // Host follows the resync with a full reset
        do_reset();
        st(fsg_pkg::FSG_STANDBY);
        $display("test resync done");
        i_proto = fsg_pkg::FSG_PROTO_QUAD;
        op(fsg_pkg::FSG_WR_VOL, 8'h00, 2'h1);
        host.frame(9, 9, 1'b0, 1'b1);
        mv(1'b1, 1'b0);
        fork
            host.frame(40, 7, 1'b0, 1'b1);
            begin
                #150;
                pin_pulse();
            end
        join
        mv(1'b1, 1'b0);
        pin_pulse();
        mv(1'b0, 1'b1);
        $display("test reset pin done");
        i_proto = fsg_pkg::FSG_PROTO_EXT;
        i_nv_direct_boot = 3'h1;
        do_reset();
        mv(1'b1, 1'b1);
        host.frame(25, 25, 1'b1, 1'b1);
        mv(1'b0, 1'b1);
        $display("test boot done");
        op(fsg_pkg::FSG_WR_VOL, 8'h00, 2'h1);
        i_proto = fsg_pkg::FSG_PROTO_DUAL;
        host.frame(17, 17, 1'b0, 1'b1);
        mv(1'b1, 1'b0);
        host.frame(13, 13, 1'b1, 1'b1);
        mv(1'b0, 1'b1);
        $display("test dual done");
        test_done();
    end
endmodule
